// ### core/lso_ctrl.sv
/*
 low speed oscillator control: apb trim register, clock divider, modes.
 assumes apb master on pclk, factory trim on a static input.
*/
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - a 32 kHz clock is made internally with no crystal
// - the low speed ticks time wake-up pulses and watchdog resets
// - the low speed clock can be selected for the digital blocks
// - reset clears the trim register, then the first clock after reset loads the factory trim value
// - in sleep the oscillator runs in a low current, less accurate state
// - bit 6 stops the oscillator when one, resets to zero
// - trim bits 5 to 0 adjust the oscillator frequency
// - the trim register is decoded at index E9h
module lso_ctrl
   import lso_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] factory_trim,
   input wire logic wdog_kick,
   output logic lso_clk,
   output logic lso_tick,
   output logic dig_clk_en,
   output logic wake_pulse,
   output logic wdog_reset,
   output logic low_current
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] low_speed_osc_trim_reg, next_trim_reg;
   logic trim_loaded, next_trim_loaded;
   logic sleep_req, next_sleep_req;
   logic sel_dig, next_sel_dig;
   logic [LSO_CNT_W-1:0] div_cnt, next_div_cnt;
   logic next_lso_clk, next_tick;
   logic [31:0] next_prdata;
   lso_state_t state, next_state;
   logic wr, rd;
   logic [LSO_CNT_W-1:0] half_lim;
   logic [5:0] low_speed_trim_field;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign low_speed_trim_field = low_speed_osc_trim_reg[LSO_TRIM_W-1:0];

   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         if (paddr != LSO_TRIM_ADDR && paddr != LSO_STAT_ADDR &&
             paddr != LSO_CTRL_ADDR) begin
            pslverr = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // registers and apb
   // ----------------------------------------
   always_comb begin
      next_trim_reg = low_speed_osc_trim_reg;
      next_trim_loaded = 1'b1;
      next_sleep_req = sleep_req;
      next_sel_dig = sel_dig;
      next_prdata = prdata;
      if (!trim_loaded) begin
         next_trim_reg = {2'b00, factory_trim};
      end else if (wr && paddr == LSO_TRIM_ADDR) begin
         next_trim_reg = pwdata[7:0] & LSO_WMASK;
      end
      if (wr && paddr == LSO_CTRL_ADDR) begin
         next_sleep_req = pwdata[LSO_CTRL_SLEEP];
         next_sel_dig = pwdata[LSO_CTRL_SELDIG];
      end
      if (rd) begin
         next_prdata = 32'h0000_0000;
         if (paddr == LSO_STAT_ADDR) begin
            next_prdata[LSO_ST_RUN] = (state == LSO_S_RUN);
            next_prdata[LSO_ST_SLEEP] = (state == LSO_S_LOWI);
            next_prdata[LSO_ST_OFF] = (state == LSO_S_OFF);
            next_prdata[LSO_ST_LOADED] = trim_loaded;
         end else if (paddr == LSO_CTRL_ADDR) begin
            next_prdata[LSO_CTRL_SLEEP] = sleep_req;
            next_prdata[LSO_CTRL_SELDIG] = sel_dig;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_speed_osc_trim_reg <= LSO_TRIM_RESET;
         trim_loaded <= 1'b0;
         sleep_req <= 1'b0;
         sel_dig <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         low_speed_osc_trim_reg <= next_trim_reg;
         trim_loaded <= next_trim_loaded;
         sleep_req <= next_sleep_req;
         sel_dig <= next_sel_dig;
         prdata <= next_prdata;
      end
   end

   // ----------------------------------------
   // mode machine
   // ----------------------------------------
   always_comb begin
      case (state)
         LSO_S_OFF: next_state = LSO_S_RUN;
         LSO_S_RUN: next_state = sleep_req ? LSO_S_LOWI : LSO_S_RUN;
         LSO_S_LOWI: next_state = sleep_req ? LSO_S_LOWI : LSO_S_RUN;
         default: next_state = LSO_S_OFF;
      endcase
      if (low_speed_osc_trim_reg[LSO_OFF_BIT] || !trim_loaded) begin
         next_state = LSO_S_OFF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= LSO_S_OFF;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // trimmed divider
   // ----------------------------------------
   always_comb begin
      // trim centred on the factory midpoint shifts the half period
      half_lim = LSO_CNT_W'(LSO_HALF) + {4'h0, low_speed_trim_field}
                 - {4'h0, LSO_FACTORY_TRIM};
      if (state == LSO_S_LOWI) begin
         half_lim = half_lim + LSO_SLEEP_EXTRA;
      end
   end

   always_comb begin
      next_div_cnt = div_cnt;
      next_lso_clk = lso_clk;
      next_tick = 1'b0;
      if (state == LSO_S_OFF) begin
         next_div_cnt = '0;
         next_lso_clk = 1'b0;
      end else if (div_cnt >= half_lim - LSO_CNT_W'(1)) begin
         next_div_cnt = '0;
         next_lso_clk = !lso_clk;
         next_tick = !lso_clk;
      end else begin
         next_div_cnt = div_cnt + LSO_CNT_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= '0;
         lso_clk <= 1'b0;
         lso_tick <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         lso_clk <= next_lso_clk;
         lso_tick <= next_tick;
      end
   end

   assign dig_clk_en = lso_tick && sel_dig;
   assign low_current = (state == LSO_S_LOWI);

   lso_timebase u_timebase (
      .pclk(pclk),
      .presetn(presetn),
      .tick(lso_tick),
      .wdog_kick(wdog_kick),
      .wake_pulse(wake_pulse),
      .wdog_reset(wdog_reset)
   );
endmodule : lso_ctrl
`default_nettype wire

// ### core/lso_pkg.sv
/*
 low speed oscillator control: shared constants.
 assumes a 10 MHz pclk and a 32-bit apb register bus.
*/
package lso_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [11:0] LSO_TRIM_INDEX = 12'h0E9;
   localparam logic [11:0] LSO_TRIM_ADDR = 12'h3A4;
   localparam logic [11:0] LSO_STAT_ADDR = 12'h3A8;
   localparam logic [11:0] LSO_CTRL_ADDR = 12'h3AC;
   // ----------------------------------------
   // fields
   // ----------------------------------------
   localparam int LSO_OFF_BIT = 6;
   localparam int LSO_TRIM_W = 6;
   localparam logic [7:0] LSO_WMASK = 8'h7F;
   localparam logic [5:0] LSO_FACTORY_TRIM = 6'h20;
   localparam logic [7:0] LSO_TRIM_RESET = 8'h00;
   localparam int LSO_ST_RUN = 0;
   localparam int LSO_ST_SLEEP = 1;
   localparam int LSO_ST_OFF = 2;
   localparam int LSO_ST_LOADED = 3;
   localparam int LSO_CTRL_SLEEP = 0;
   localparam int LSO_CTRL_SELDIG = 1;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int LSO_CLK_HZ = 10000000;
   localparam int LSO_NOM_HZ = 32000;
   localparam int LSO_HALF = LSO_CLK_HZ / (2 * LSO_NOM_HZ);
   localparam int LSO_CNT_W = 10;
   localparam int LSO_WAKE_TICKS = 32;
   localparam int LSO_WDOG_TICKS = 96;
   localparam logic [LSO_CNT_W-1:0] LSO_SLEEP_EXTRA = 10'h040;
   typedef enum logic [2:0] {
      LSO_S_OFF = 3'b001,
      LSO_S_RUN = 3'b010,
      LSO_S_LOWI = 3'b100
   } lso_state_t;
endpackage : lso_pkg

// ### core/lso_timebase.sv
/*
 low speed oscillator: wake and watchdog tick generator.
 assumes a one-cycle enable per low speed clock tick.
*/
`timescale 1ns/1ps
`default_nettype none
module lso_timebase
   import lso_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic wdog_kick,
   output logic wake_pulse,
   output logic wdog_reset
);
   logic [7:0] wake_cnt, next_wake_cnt;
   logic [7:0] wdog_cnt, next_wdog_cnt;
   logic next_wake, next_wdog;

   always_comb begin
      next_wake_cnt = wake_cnt;
      next_wdog_cnt = wdog_cnt;
      next_wake = 1'b0;
      next_wdog = 1'b0;
      if (wdog_kick) begin
         next_wdog_cnt = 8'h00;
      end
      if (tick) begin
         if (wake_cnt == 8'(LSO_WAKE_TICKS - 1)) begin
            next_wake_cnt = 8'h00;
            next_wake = 1'b1;
         end else begin
            next_wake_cnt = wake_cnt + 8'h01;
         end
         if (!wdog_kick) begin
            if (wdog_cnt == 8'(LSO_WDOG_TICKS - 1)) begin
               next_wdog_cnt = 8'h00;
               next_wdog = 1'b1;
            end else begin
               next_wdog_cnt = wdog_cnt + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt <= 8'h00;
         wdog_cnt <= 8'h00;
         wake_pulse <= 1'b0;
         wdog_reset <= 1'b0;
      end else begin
         wake_cnt <= next_wake_cnt;
         wdog_cnt <= next_wdog_cnt;
         wake_pulse <= next_wake;
         wdog_reset <= next_wdog;
      end
   end
endmodule : lso_timebase
`default_nettype wire

// ### dv/lso_ctrl_chk.sv
/* port checker for lso_ctrl.
 bound to the design from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module lso_ctrl_chk
   import lso_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic lso_tick,
   input wire logic lso_clk,
   input wire logic dig_clk_en,
   input wire logic wake_pulse,
   input wire logic wdog_reset
);
   // ------------------------------
   // helpers
   // ------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   logic hit;
   assign acc = psel & penable;
   assign hit = paddr == LSO_TRIM_ADDR || paddr == LSO_STAT_ADDR
      || paddr == LSO_CTRL_ADDR;
   // ------------------------------
   // assertions
   // ------------------------------
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_err_unmapped: assert property (acc |-> pslverr == !hit)
      else $error("pslverr wrong");
   a_rd_unmapped: assert property (acc && !pwrite && !hit |-> prdata == 0)
      else $error("unmapped read not zero");
   a_tick_gap: assert property (lso_tick |=> !lso_tick [*8])
      else $error("ticks too close");
   a_dig_gated: assert property (dig_clk_en |-> lso_tick)
      else $error("digital enable without tick");
   a_wake_gap: assert property (wake_pulse |=> !wake_pulse [*8])
      else $error("wake pulses too close");
   a_wdog_once: assert property (wdog_reset |=> !wdog_reset [*8])
      else $error("watchdog pulse too long");
   a_off_quiet: assert property (acc && pwrite && paddr == LSO_TRIM_ADDR
      && pwdata[6] |=> ##2 (!lso_tick && !lso_clk) [*6])
      else $error("clock runs while off");
endmodule : lso_ctrl_chk
`default_nettype wire

// ### dv/lso_ctrl_tb_top.sv
/* self-checking bench for lso_ctrl.
 drives apb and watches the clock outputs. */
`timescale 1ns/1ps
`default_nettype none
module lso_ctrl_tb_top;
   import lso_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic wdog_kick = 0, pready, pslverr, lso_clk, lso_tick, er;
   logic dig_clk_en, wake_pulse, wdog_reset, low_current;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [5:0] factory_trim = 6'h15;
   int err_total = 0, checks = 0, cyc = 0, c, n, w1, w2;
   always #50 pclk = ~pclk;
   lso_ctrl DUT(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .factory_trim(factory_trim), .wdog_kick(wdog_kick),
      .lso_clk(lso_clk), .lso_tick(lso_tick), .dig_clk_en(dig_clk_en),
      .wake_pulse(wake_pulse), .wdog_reset(wdog_reset),
      .low_current(low_current));
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int k;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) err_total++;
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   task automatic tick();
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (lso_tick !== 1'b1 && n < 3000);
      if (lso_tick !== 1'b1) err_total++;
      c = n;
   endtask : tick
   task automatic per(input int e);
      repeat (3) tick();
      chk(c, e);
   endtask : per
   task automatic final_report();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         err_total++;
         final_report();
      end
   end
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_regs();
      apb(0, LSO_TRIM_ADDR, 0);
      chk(rd, 32'h0);
      per(290);
      apb(0, LSO_STAT_ADDR, 0);
      chk(rd, 32'h9);
      apb(1, LSO_TRIM_ADDR, 32'hFFFFFF9F);
      per(310);
      apb(0, 12'h3B0, 0);
      chk(er, 1);
      chk(rd, 32'h0);
   endtask : t_regs
   task automatic t_freq();
      apb(1, LSO_TRIM_ADDR, 32'h24);
      per(320);
      apb(1, LSO_TRIM_ADDR, 32'h20);
      per(312);
      apb(1, LSO_CTRL_ADDR, 32'h1);
      per(440);
      chk(low_current, 1);
      apb(1, LSO_CTRL_ADDR, 32'h0);
   endtask : t_freq
   task automatic t_off();
      apb(1, LSO_TRIM_ADDR, 32'h60);
      repeat (4) @(posedge pclk);
      w1 = 0;
      repeat (800) begin
         @(posedge pclk);
         if (lso_tick !== 1'b0 || lso_clk !== 1'b0) w1++;
      end
      chk(w1, 0);
      apb(0, LSO_STAT_ADDR, 0);
      chk(rd, 32'hC);
      apb(1, LSO_TRIM_ADDR, 32'h20);
   endtask : t_off
   task automatic t_dig();
      apb(1, LSO_CTRL_ADDR, 32'h2);
      tick();
      chk(dig_clk_en, 1);
      apb(1, LSO_CTRL_ADDR, 32'h0);
      tick();
      chk(dig_clk_en, 0);
   endtask : t_dig
   task automatic t_wake();
      wdog_kick <= 1;
      @(posedge pclk);
      wdog_kick <= 0;
      n = 0;
      w1 = 0;
      w2 = 0;
      repeat (40000) begin
         @(posedge pclk);
         if (wdog_reset === 1'b1) break;
         if (lso_tick === 1'b1) n++;
         if (wake_pulse === 1'b1) begin
            w2 = w1;
            w1 = n;
         end
      end
      chk(n, 96);
      chk(w1 - w2, 32);
   endtask : t_wake
   task automatic t_reset();
      presetn <= 0;
      factory_trim <= 6'h28;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, LSO_STAT_ADDR, 0);
      chk(rd, 32'hC);
      per(328);
   endtask : t_reset
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_regs();
      t_freq();
      t_off();
      t_dig();
      t_wake();
      t_reset();
      final_report();
   end
endmodule : lso_ctrl_tb_top
bind lso_ctrl lso_ctrl_chk u_chk(.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .lso_tick(lso_tick), .lso_clk(lso_clk), .dig_clk_en(dig_clk_en),
   .wake_pulse(wake_pulse), .wdog_reset(wdog_reset));
`default_nettype wire
